// [hw/css_pkg.sv]
// Package for the configuration start-up sequencer: states, timing, carriers
package css_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS       = 10;   // System clock period
    localparam int SRAM_CLEAR_TIME_NS  = 2000; // Least SRAM clear interval
    // Least time rounds up to whole cycles
    localparam int SRAM_CLEAR_CYCLES   =
        (SRAM_CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CNT_W         = 16;   // Clear counter width

    // ********************************************************************
    // Fetch source selection
    // ********************************************************************
    localparam logic SRC_INTERNAL = 1'b0;      // Internal non-volatile memory
    localparam logic SRC_SPI      = 1'b1;      // External SPI flash

    // ********************************************************************
    // Sequencer states
    // ********************************************************************
    typedef enum logic [2:0] {
        CSS_POR,                               // Power-on reset held
        CSS_INIT,                              // Clearing SRAM
        CSS_CONFIG,                            // Fetching configuration
        CSS_ERROR,                             // Bad data, never operate
        CSS_DONE                               // Handed to wake-up
    } css_state_t;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    // One word of configuration data from a memory source
    typedef struct packed {
        logic        valid;                    // Word present
        logic        last;                     // Final word of image
        logic        error;                    // Source flagged bad data
        logic [31:0] data;                     // Configuration word
    } css_word_t;

    // Open-drain pin as three signals; enable low while driving
    typedef struct packed {
        logic in;                              // Level sensed on the pin
        logic out;                             // Level driven
        logic oe_n;                            // Low while driving
    } css_od_pin_t;

endpackage : css_pkg

// [hw/css_clear_timer.sv]
// SRAM clear interval timer for the start-up sequencer
`timescale 1ns/1ns

module css_clear_timer #(
    parameter int CNT_W     = css_pkg::CLEAR_CNT_W,
    parameter int TERMINAL  = css_pkg::SRAM_CLEAR_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic restart_i,              // Clear count and flag; no counting while high
    input  wire logic run_i,                  // Count while high
    // Status
    output logic      expired_o               // Interval has elapsed
);

    localparam logic [CNT_W-1:0] TERM_CNT = CNT_W'(TERMINAL);

    logic [CNT_W-1:0] count;                  // Cycles counted so far

    // ********************************************************************
    // Counter: saturates at the terminal count
    // ********************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || restart_i) begin
            count     <= '0;
            expired_o <= 1'b0;
        end else if (run_i && !expired_o) begin
            count <= count + CNT_W'(1);
            // Flag set on the cycle the count reaches the end
            if (count + CNT_W'(1) >= TERM_CNT) begin
                expired_o <= 1'b1;
            end
        end
    end

endmodule : css_clear_timer

// [hw/css_sequencer.sv]
// Configuration start-up sequencer: reset, SRAM clear, configuration fetch
`timescale 1ns/1ns

// Notes on behaviour
// - Pins high impedance while power-on reset active
// - On reset release drive status, done low
// - Initialization clears SRAM, status held low
// - Leave init after time, request released, pin high
// - External low on status pin stalls configuration
// - Rising status edge enters configuration state
// - Fetch from internal memory or SPI flash
// - No valid image: stay in configuration until reprogram or refresh
// - Status high while fine, low on error
// - Offline update suspends user logic unless transparent mode is on
// - Transparent mode keeps user logic running
// - Correct image sets internal completion flag
// - Reprogram or refresh drives pins low, reinit
module css_sequencer #(
    parameter int CLEAR_CYCLES = css_pkg::SRAM_CLEAR_CYCLES,
    parameter int CNT_W        = css_pkg::CLEAR_CNT_W
) (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,          // Power-on reset strobe
    // Status pin, open drain
    input  wire logic              clear_error_status_n_i,
    output logic                   clear_error_status_n_o,
    output logic                   clear_error_status_n_oe_n_o,
    // Completion pin
    output logic                   done_pin_o,
    output logic                   done_pin_oe_n_o,
    // Reprogram request pin, active low
    input  wire logic              reprogram_request_n_i,
    // Refresh command from a configuration port
    input  wire logic              refresh_cmd_i,
    // Source selection and memory words
    input  wire logic              src_sel_i,      // Internal or SPI
    input  wire logic              int_image_valid_i,
    input  wire logic              spi_image_valid_i,
    input  wire css_pkg::css_word_t int_word_i,
    input  wire css_pkg::css_word_t spi_word_i,
    output logic                   int_fetch_o,    // Request from internal
    output logic                   spi_fetch_o,    // Request from SPI flash
    // SRAM write path
    output logic                   sram_clear_o,   // Clearing all cells
    output logic                   sram_we_o,
    output logic [31:0]            sram_data_o,
    // Update modes
    input  wire logic              offline_update_i,
    input  wire logic              transparent_update_i,
    // Status to the rest of the device
    output logic                   config_done_o,  // Starts wake-up
    output logic                   config_error_o,
    output logic                   user_logic_en_o,
    output logic                   io_hiz_o        // All user pins released
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    css_pkg::css_state_t state;                    // Current state
    css_pkg::css_state_t next_state;               // Next state
    logic                status_meta;              // Status sync stage 1
    logic                status_sync;              // Status sync stage 2
    logic                status_prev;              // Previous synced level
    logic                reprog_meta;              // Request sync stage 1
    logic                reprog_sync_n;            // Request sync stage 2
    logic                clear_expired;            // Clear interval done
    logic                status_rise;              // Rising edge on pin
    logic                restart_seq;              // Reprogram or refresh
    logic                src_valid;                // Selected image valid
    css_pkg::css_word_t  cur_word;                 // Word from selection
    logic                released;                 // Device stopped driving

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    // Two flops before anything reads the external pins
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            status_meta   <= 1'b1;          // Pulled-up idle level
            status_sync   <= 1'b1;
            reprog_meta   <= 1'b1;
            reprog_sync_n <= 1'b1;
        end else begin
            status_meta   <= clear_error_status_n_i;
            status_sync   <= status_meta;
            reprog_meta   <= reprogram_request_n_i;
            reprog_sync_n <= reprog_meta;
        end
    end

    // Edge detector reads only the second stage
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            status_prev <= 1'b1;              // No false rise after reset
        end else begin
            status_prev <= status_sync;
        end
    end

    // ********************************************************************
    // Combinational helpers
    // ********************************************************************
    assign status_rise = status_sync && !status_prev;
    assign restart_seq = !reprog_sync_n || refresh_cmd_i;
    // Source choice is a plain mux; only one source feeds SRAM at a time
    assign src_valid = (src_sel_i == css_pkg::SRC_SPI) ?
                       spi_image_valid_i : int_image_valid_i;
    assign cur_word  = (src_sel_i == css_pkg::SRC_SPI) ?
                       spi_word_i : int_word_i;

    // ********************************************************************
    // Clear interval timer
    // ********************************************************************
    css_clear_timer #(
        .CNT_W     (CNT_W),
        .TERMINAL  (CLEAR_CYCLES)
    ) u_clear_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .restart_i (state != css_pkg::CSS_INIT),
        .run_i     (state == css_pkg::CSS_INIT),
        .expired_o (clear_expired)
    );

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            css_pkg::CSS_POR: begin
                // Reset released: start clearing
                next_state = css_pkg::CSS_INIT;
            end
            css_pkg::CSS_INIT: begin
                // Pin sensing only counts once we have let go of it;
                // any external low keeps the edge from ever appearing
                if (released && reprog_sync_n && status_rise) begin
                    next_state = css_pkg::CSS_CONFIG;
                end
            end
            css_pkg::CSS_CONFIG: begin
                if (!src_valid) begin
                    next_state = css_pkg::CSS_CONFIG;
                end else if (cur_word.valid && cur_word.error) begin
                    next_state = css_pkg::CSS_ERROR;
                end else if (cur_word.valid && cur_word.last) begin
                    next_state = css_pkg::CSS_DONE;
                end
            end
            css_pkg::CSS_ERROR: begin
                next_state = css_pkg::CSS_ERROR;
            end
            css_pkg::CSS_DONE: begin
                next_state = css_pkg::CSS_DONE;
            end
        endcase
        // Reprogram or refresh wins from any state after reset
        if (restart_seq && state != css_pkg::CSS_POR) begin
            next_state = css_pkg::CSS_INIT;
        end
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= css_pkg::CSS_POR;
        end else begin
            state <= next_state;
        end
    end

    // ********************************************************************
    // Status pin release
    // ********************************************************************
    // Let go of the pin only once the clear interval is over and the
    // reprogram request has gone away; until then we drive it low
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            released <= 1'b0;
        end else if (state != css_pkg::CSS_INIT || restart_seq) begin
            released <= 1'b0;
        end else if (clear_expired && reprog_sync_n) begin
            released <= 1'b1;
        end
    end

    // ********************************************************************
    // Pin drivers
    // ********************************************************************
    // Status pin: driven low in init (until release) and after error;
    // otherwise released and pulled high externally
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            clear_error_status_n_o      <= 1'b0;
            clear_error_status_n_oe_n_o <= 1'b1;
        end else begin
            clear_error_status_n_o <= 1'b0;
            unique case (next_state)
                css_pkg::CSS_POR: begin
                    clear_error_status_n_oe_n_o <= 1'b1;
                end
                css_pkg::CSS_INIT: begin
                    // Hold low while clearing; a fresh restart relowers,
                    // release follows the flag's own set condition
                    clear_error_status_n_oe_n_o <= !restart_seq &&
                        (released || (clear_expired && reprog_sync_n &&
                         state == css_pkg::CSS_INIT));
                end
                css_pkg::CSS_ERROR: begin
                    clear_error_status_n_oe_n_o <= 1'b0;
                end
                default: begin
                    clear_error_status_n_oe_n_o <= 1'b1;
                end
            endcase
        end
    end

    // Completion pin: low until configuration is done, high-z in reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            done_pin_o      <= 1'b0;
            done_pin_oe_n_o <= 1'b1;
        end else begin
            done_pin_o      <= 1'b0;
            // Released at done so wake-up owns the final level
            done_pin_oe_n_o <= (next_state == css_pkg::CSS_DONE);
        end
    end

    // ********************************************************************
    // Fetch and SRAM path
    // ********************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            int_fetch_o  <= 1'b0;
            spi_fetch_o  <= 1'b0;
            sram_clear_o <= 1'b0;
            sram_we_o    <= 1'b0;
            sram_data_o  <= '0;
        end else begin
            sram_clear_o <= (next_state == css_pkg::CSS_INIT);
            int_fetch_o  <= (next_state == css_pkg::CSS_CONFIG) &&
                            (src_sel_i == css_pkg::SRC_INTERNAL);
            spi_fetch_o  <= (next_state == css_pkg::CSS_CONFIG) &&
                            (src_sel_i == css_pkg::SRC_SPI);
            // Bad words never reach SRAM
            sram_we_o    <= (state == css_pkg::CSS_CONFIG) && src_valid
                            && cur_word.valid && !cur_word.error;
            if (cur_word.valid) begin
                sram_data_o <= cur_word.data;
            end
        end
    end

    // ********************************************************************
    // Device status
    // ********************************************************************
    // Transparent update leaves user logic alone; offline stops it unless transparent is set
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            config_done_o   <= 1'b0;
            config_error_o  <= 1'b0;
            user_logic_en_o <= 1'b0;
            io_hiz_o        <= 1'b1;
        end else begin
            config_done_o   <= (next_state == css_pkg::CSS_DONE);
            config_error_o  <= (next_state == css_pkg::CSS_ERROR);
            user_logic_en_o <= (next_state == css_pkg::CSS_DONE) &&
                               (!offline_update_i ||
                                transparent_update_i);
            io_hiz_o        <= (next_state == css_pkg::CSS_POR);
        end
    end

endmodule : css_sequencer

// [sim/css_seq_asserts.sv]
// Port checker for the configuration start-up sequencer
`timescale 1ns/1ns

module css_seq_asserts #(
    parameter int CLEAR_CYCLES = 4,   // Clear interval in cycles
    parameter int CNT_W        = 16   // Clear counter width
) (
    // Clock and reset
    input wire logic               sys_clk_i,
    input wire logic               rst_i,
    // Pins
    input wire logic               clear_error_status_n_i,
    input wire logic               clear_error_status_n_oe_n_o,
    input wire logic               done_pin_oe_n_o,
    input wire logic               reprogram_request_n_i,
    // Fetch and SRAM path
    input wire logic               src_sel_i,
    input wire css_pkg::css_word_t int_word_i,
    input wire css_pkg::css_word_t spi_word_i,
    input wire logic               int_fetch_o,
    input wire logic               spi_fetch_o,
    input wire logic               sram_clear_o,
    input wire logic               sram_we_o,
    input wire logic [31:0]        sram_data_o,
    // Status
    input wire logic               offline_update_i,
    input wire logic               config_done_o,
    input wire logic               config_error_o,
    input wire logic               user_logic_en_o,
    input wire logic               io_hiz_o
);
    // One domain, so clock and reset are stated once
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    // ****************************************************************
    // Sequences
    // ****************************************************************
    sequence s_release;                         // First edge out of reset
        $fell(rst_i);
    endsequence
    sequence s_clear_start;                     // SRAM clearing begins
        $rose(sram_clear_o);
    endsequence
    sequence s_stalled;                         // Status held low in clear
        !clear_error_status_n_i [*3] ##0 sram_clear_o;
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    hiz_reset_a: assert property (
        s_release |-> io_hiz_o && clear_error_status_n_oe_n_o
            && done_pin_oe_n_o) else $error("pins driven in reset");
    pins_low_a: assert property (
        s_release |=> !clear_error_status_n_oe_n_o && !done_pin_oe_n_o
            && sram_clear_o && !io_hiz_o) else $error("no init entry");
    clear_hold_a: assert property (
        s_clear_start |-> !clear_error_status_n_oe_n_o [*4])
        else $error("status released early");
    reprog_low_a: assert property (
        !reprogram_request_n_i [*5] |-> !clear_error_status_n_oe_n_o
            && !done_pin_oe_n_o && !config_done_o)
        else $error("reprogram request ignored");
    stall_hold_a: assert property (
        s_stalled |=> !int_fetch_o && !spi_fetch_o)
        else $error("fetch while status held low");
    fetch_excl_a: assert property (
        (int_fetch_o || spi_fetch_o) |-> !(int_fetch_o && spi_fetch_o)
            && !sram_clear_o && clear_error_status_n_oe_n_o)
        else $error("bad fetch select");
    sram_write_a: assert property (
        sram_we_o |-> sram_data_o == ($past(src_sel_i) ?
            $past(spi_word_i.data) : $past(int_word_i.data)))
        else $error("wrong word written");
    error_pin_a: assert property (
        config_error_o |-> !clear_error_status_n_oe_n_o
            && !user_logic_en_o && !config_done_o)
        else $error("error not signalled");
    done_flag_a: assert property (
        config_done_o |-> done_pin_oe_n_o && !sram_clear_o)
        else $error("done flag out of state");
    user_offline_a: assert property (
        offline_update_i |=> !user_logic_en_o)
        else $error("user logic ran offline");
    user_done_a: assert property (
        user_logic_en_o |-> config_done_o)
        else $error("user logic before done");
endmodule : css_seq_asserts

bind css_sequencer css_seq_asserts #(
    .CLEAR_CYCLES(CLEAR_CYCLES),
    .CNT_W       (CNT_W)
) u_css_seq_asserts (
    .sys_clk_i, .rst_i, .clear_error_status_n_i,
    .clear_error_status_n_oe_n_o, .done_pin_oe_n_o,
    .reprogram_request_n_i, .src_sel_i, .int_word_i, .spi_word_i,
    .int_fetch_o, .spi_fetch_o, .sram_clear_o, .sram_we_o, .sram_data_o,
    .offline_update_i, .config_done_o, .config_error_o, .user_logic_en_o,
    .io_hiz_o
);

// [sim/css_partner.sv]
// Far-side model: chain master on the status pin and an image memory
`timescale 1ns/1ns

module css_partner (
    // Clock
    input  wire logic          sys_clk_i,
    // Bench controls
    input  wire logic          hold_low_i, // Master holds status low
    input  wire logic          gap_i,      // Slow memory skips a cycle
    input  wire logic          rewind_i,   // Restart the image
    input  wire logic [7:0]    words_i,    // Image length in words
    input  wire logic [7:0]    bad_i,      // Index of the corrupt word
    // Device side
    input  wire logic          fetch_i,    // Device is reading
    input  wire logic          dev_oe_n_i, // Device pulls status low
    output logic               pin_o,      // Resolved status level
    output css_pkg::css_word_t word_o      // Word offered to the device
);
    logic [7:0] idx;                       // Next word to offer
    logic [7:0] tick;                      // Free count for idle data
    logic       avail;                     // A word is on offer

    // Pull-up wins unless either party pulls low
    assign pin_o = !(hold_low_i || !dev_oe_n_i);

    // One source at a time, so no port preemption can arise
    assign avail = fetch_i && !gap_i && (idx < words_i);

    // Idle data changes every cycle so a stale word never looks good
    assign word_o = avail ? {1'b1, idx == words_i - 8'h01, idx == bad_i,
                             32'hC0DE_0000 | {24'h0, idx}}
                          : {3'b000, {4{tick}}};

    // Advance past each word the device took
    always_ff @(posedge sys_clk_i) begin
        tick <= rewind_i ? 8'h00 : tick + 8'h01;
        if (rewind_i)
            idx <= 8'h00;
        else if (avail)
            idx <= idx + 8'h01;
    end
endmodule : css_partner

// [sim/tb.sv]
// Self-checking bench for the configuration start-up sequencer
`timescale 1ns/1ns

module tb;
    localparam int CLR   = 4;       // Short clear keeps runs brief
    localparam int LIMIT = 20000;   // Hang guard
    logic               sys_clk_i, rst_i, reprogram_request_n_i;
    logic               refresh_cmd_i, src_sel_i, int_image_valid_i;
    logic               spi_image_valid_i, offline_update_i;
    logic               transparent_update_i, clear_error_status_n_o;
    logic               clear_error_status_n_oe_n_o, done_pin_o;
    logic               done_pin_oe_n_o, int_fetch_o, spi_fetch_o;
    logic               sram_clear_o, sram_we_o, config_done_o;
    logic               config_error_o, user_logic_en_o, io_hiz_o;
    logic               hold, gap, rewind;
    logic [7:0]         nw, bad;
    logic [31:0]        sram_data_o;
    wire logic          clear_error_status_n_i;
    css_pkg::css_word_t int_word_i, spi_word_i, pw;
    int                 error_cnt, comparisons, cycle_cnt, r, n, b;
    integer             seed;
    logic [31:0]        exp_q[$];   // Words the model expects written

    // Clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Unselected source sees idle noise
    assign int_word_i = src_sel_i ? {3'b000, ~pw.data} : pw;
    assign spi_word_i = src_sel_i ? pw : {3'b000, ~pw.data};

    css_sequencer #(.CLEAR_CYCLES(CLR)) u_css_sequencer (
        .sys_clk_i, .rst_i, .clear_error_status_n_i,
        .clear_error_status_n_o, .clear_error_status_n_oe_n_o,
        .done_pin_o, .done_pin_oe_n_o, .reprogram_request_n_i,
        .refresh_cmd_i, .src_sel_i, .int_image_valid_i,
        .spi_image_valid_i, .int_word_i, .spi_word_i, .int_fetch_o,
        .spi_fetch_o, .sram_clear_o, .sram_we_o, .sram_data_o,
        .offline_update_i, .transparent_update_i, .config_done_o,
        .config_error_o, .user_logic_en_o, .io_hiz_o
    );
    css_partner u_css_partner (
        .sys_clk_i, .hold_low_i(hold), .gap_i(gap), .rewind_i(rewind),
        .words_i(nw), .bad_i(bad), .fetch_i(int_fetch_o | spi_fetch_o),
        .dev_oe_n_i(clear_error_status_n_oe_n_o),
        .pin_o(clear_error_status_n_i), .word_o(pw)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // Golden model and hang guard at the settled edge
    always @(negedge sys_clk_i) begin
        cycle_cnt++;
        gap = 1'($random(seed));            // Random memory stalls
        if (cycle_cnt == LIMIT) begin
            error_cnt++;
            close_out();
        end
        if (!rst_i && sram_we_o === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check(sram_data_o, exp_q.pop_front());
        end
    end

    // Back to clearing by request pin or refresh
    task automatic reinit(input logic by_pin);
        hold = ~by_pin;                     // Pin path: request alone holds
        if (by_pin) begin
            reprogram_request_n_i = 1'b0;
            repeat (CLR + 20) @(negedge sys_clk_i);
            check(32'(clear_error_status_n_oe_n_o | int_fetch_o), 32'h0);
            hold = 1'b1;
        end else begin
            refresh_cmd_i = 1'b1;
            @(negedge sys_clk_i);
            refresh_cmd_i = 1'b0;
            repeat (3) @(negedge sys_clk_i);
        end
        check({clear_error_status_n_oe_n_o, done_pin_oe_n_o, config_done_o,
               sram_clear_o, done_pin_o}, 32'h2);
    endtask : reinit

    // Release the chain late, stream one image
    task automatic boot(input logic s, input logic ok, input int cnt,
                        input int bad_at, input int stall);
        int k;
        src_sel_i = s;
        int_image_valid_i = ok & !s;
        spi_image_valid_i = ok & s;
        nw = ok ? 8'(cnt) : 8'h00;
        bad = 8'(bad_at);
        reprogram_request_n_i = 1'b1;
        rewind = 1'b1;
        for (k = 0; k < cnt && k < bad_at && ok; k++)
            exp_q.push_back(32'hC0DE_0000 | 32'(k));
        @(negedge sys_clk_i);
        rewind = 1'b0;
        repeat (stall) @(negedge sys_clk_i);
        check(32'(int_fetch_o | spi_fetch_o), 32'h0);
        hold = 1'b0;
        k = 0;
        while (config_done_o !== 1'b1 && config_error_o !== 1'b1
               && k < 300) begin
            @(negedge sys_clk_i);
            k++;
        end
        // Let the golden model take the last write before counting
        @(negedge sys_clk_i);
        check({config_done_o, config_error_o},
              !ok ? 32'h0 : bad_at < cnt ? 32'h1 : 32'h2);
        check(32'(exp_q.size()), 32'h0);
    endtask : boot

    // Main sequence
    initial begin
        seed = 32'hFE1E5A49;
        {error_cnt, comparisons, cycle_cnt} = '0;
        {rst_i, hold, rewind, reprogram_request_n_i} = 4'hF;
        {gap, refresh_cmd_i, src_sel_i, int_image_valid_i} = 4'h0;
        {spi_image_valid_i, offline_update_i, transparent_update_i} = 3'h0;
        nw = 8'h00;
        bad = 8'hFF;
        repeat (4) @(negedge sys_clk_i);
        check({io_hiz_o, clear_error_status_n_oe_n_o, done_pin_oe_n_o},
              32'h7);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        check({clear_error_status_n_oe_n_o, done_pin_oe_n_o, sram_clear_o,
               io_hiz_o}, 32'h2);
        boot(1'b0, 1'b1, 5, 255, CLR + 8);
        check({done_pin_oe_n_o, user_logic_en_o}, 32'h3);
        offline_update_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check(32'(user_logic_en_o), 32'h0);
        offline_update_i = 1'b0;
        transparent_update_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check(32'(user_logic_en_o), 32'h1);
        transparent_update_i = 1'b0;
        // Both reinit paths, both sources, bad and empty images
        for (r = 0; r < 8; r++) begin
            n = 2 + ($random(seed) & 7);
            b = (r % 3 == 1) ? int'($unsigned($random(seed)) % n) : 255;
            reinit(r[0]);
            boot(r[1], r != 6, n, b, CLR + 8 + r);
            if (b < n)
                check(32'(clear_error_status_n_oe_n_o | user_logic_en_o |
                          clear_error_status_n_o), 32'h0);
        end
        close_out();
    end
endmodule : tb
